// [src/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

  // saved processor context, one shadow copy of each field
  typedef struct packed {
    logic [7:0]  w;
    logic [7:0]  status;
    logic [4:0]  bank_select_reg;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
    logic [6:0]  pc_high_latch;
  } ctx_t;

  localparam logic [15:0] VECTOR_ADDR = 16'h0004;

  // byte addresses of the register slave
  localparam logic [7:0] OFS_CORE_CTL  = 8'h00;
  localparam logic [7:0] OFS_PFLAG_A   = 8'h04;
  localparam logic [7:0] OFS_PFLAG_B   = 8'h08;
  localparam logic [7:0] OFS_PEN_A     = 8'h0C;
  localparam logic [7:0] OFS_PEN_B     = 8'h10;
  localparam logic [7:0] OFS_EDGE_CFG  = 8'h14;
  localparam logic [7:0] OFS_PIN_CHG   = 8'h18;
  localparam logic [7:0] OFS_STATE     = 8'h1C;
  localparam logic [7:0] OFS_SH_W      = 8'h20;
  localparam logic [7:0] OFS_SH_STATUS = 8'h24;
  localparam logic [7:0] OFS_SH_BSR    = 8'h28;
  localparam logic [7:0] OFS_SH_FSR0   = 8'h2C;
  localparam logic [7:0] OFS_SH_FSR1   = 8'h30;
  localparam logic [7:0] OFS_SH_PC_HIGH_LATCH = 8'h34;

  // core_irq_control field positions
  localparam int CTL_GIE  = 7;
  localparam int CTL_PERIPHERAL_GROUP_ENABLE = 6;
  localparam int CTL_T0IE = 5;
  localparam int CTL_EIE  = 4;
  localparam int CTL_CIE  = 3;
  localparam int CTL_T0IF = 2;
  localparam int CTL_EIF  = 1;
  localparam int CTL_CIF  = 0;

  // status bits not carried through the shadow copy
  localparam int STATUS_TO_BIT = 4;
  localparam int STATUS_PD_BIT = 3;

  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE_STEP} run_state_t;

endpackage : irq_ctrl_pkg

// [src/core_interrupt_controller.sv]
`timescale 1ns/1ps
// Contract
// R1: reset leaves every interrupt disabled
// R2: redirect needs global, own and group enables; here the group enable gates only the peripheral sources
// R3: flags set regardless of any enable
// R4: entry flushes, clears global, pushes, saves, vectors
// R5: service routine polls and clears serviced flags
// R6: events during service only set flags
// R7: return pops, restores context, sets global enable
// R8: pending flag taken once global enable returns
// R9: synchronous source reaches vector in 3-4 cycles
// R10: asynchronous source reaches vector in 3-5 cycles
// R11: latency independent of instruction length
// R12: edge flag sampled once per cycle at Q1
// R13: firmware enables wake sources before sleep
// R14: wake vectors only with global enable set
// R15: instruction after sleep always executes first
// R16: pin edge selectable rising or falling
// R17: valid edge sets flag, may redirect
// R18: entry copies context, status minus TO/PD
// R19: return restores shadows, discarding live changes
// R20: shadows software accessible, written value restored
// R21: control register bit order fixed
// R22: change summary flag read-only, follows pin flags
// R23: request is global AND gated flag-enable pairs
module core_interrupt_controller #(
  parameter int NPERIPH = 8
) (
  input  wire logic                  clk,             // 125 MHz clock
  input  wire logic                  rst,             // async, high
  input  wire logic [7:0]            avs_address,     // byte address
  input  wire logic                  avs_read,        // read request
  input  wire logic                  avs_write,       // write request
  input  wire logic [31:0]           avs_writedata,   // write data
  input  wire logic [3:0]            avs_byteenable,  // byte lanes
  output logic [31:0]                avs_readdata,    // read data
  output logic                       avs_waitrequest, // stall
  input  wire logic                  q1_tick,         // core Q1 phase
  input  wire logic                  timer0_ovf_evt,  // sync event
  input  wire logic [NPERIPH-1:0]    periph_evt_a,    // sync events
  input  wire logic [NPERIPH-1:0]    periph_evt_b,    // sync events
  input  wire logic [7:0]            pin_change_evt,  // sync events
  input  wire logic                  ext_irq_pin,     // async pin
  input  wire logic                  sleep_enter,     // core sleeps
  input  wire logic                  return_from_irq_op, // return_from_irq_op pulse
  input  wire irq_ctrl_pkg::ctx_t    ctx_live,        // live context
  output logic                       irq_take,        // vector pulse
  output logic [15:0]                vector_addr,     // pc load value
  output logic                       wake,            // wake pulse
  output logic                       ctx_restore_valid, // restore pulse
  output irq_ctrl_pkg::ctx_t         ctx_restore      // restored ctx
);

  logic                  global_irq_enable;
  logic                  peripheral_group_enable;
  logic                  timer0_ovf_enable;
  logic                  edge_irq_enable;
  logic                  change_irq_enable;
  logic                  timer0_ovf_flag;
  logic                  edge_irq_flag;
  logic                  edge_polarity_select;
  logic [NPERIPH-1:0]    periph_flag_reg_a;
  logic [NPERIPH-1:0]    periph_flag_reg_b;
  logic [NPERIPH-1:0]    periph_enable_a;
  logic [NPERIPH-1:0]    periph_enable_b;
  logic [7:0]            pin_change_flags;
  irq_ctrl_pkg::ctx_t    shadow;
  irq_ctrl_pkg::run_state_t state;
  logic                  pin_s1;
  logic                  pin_s2;
  logic                  pin_s3;

  // bus decode
  wire        wr_acc = avs_write && !avs_waitrequest;
  wire        rd_go  = avs_read && avs_waitrequest;
  wire        be0    = avs_byteenable[0];
  wire        be1    = avs_byteenable[1];
  wire [7:0]  wd     = avs_writedata[7:0];
  wire [15:0] wd16   = avs_writedata[15:0];
  wire wr_ctl  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_CORE_CTL;
  wire wr_pfa  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_PFLAG_A;
  wire wr_pfb  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_PFLAG_B;
  wire wr_pea  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_PEN_A;
  wire wr_peb  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_PEN_B;
  wire wr_ecfg = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_EDGE_CFG;
  wire wr_pchg = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_PIN_CHG;
  wire wr_shw  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_SH_W;
  wire wr_shs  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_SH_STATUS;
  wire wr_shb  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_SH_BSR;
  wire wr_shp  = wr_acc && be0 && avs_address == irq_ctrl_pkg::OFS_SH_PC_HIGH_LATCH;
  wire sel_f0  = wr_acc && avs_address == irq_ctrl_pkg::OFS_SH_FSR0;
  wire sel_f1  = wr_acc && avs_address == irq_ctrl_pkg::OFS_SH_FSR1;

  // summary flag has no storage of its own R22
  wire change_summary_flag = |pin_change_flags; // R22

  // external edge detect on synchronised pin R16
  wire pin_edge = edge_polarity_select ? (pin_s2 && !pin_s3)
                                       : (!pin_s2 && pin_s3); // R16

  // request qualification R2 R23
  wire core_pend = (timer0_ovf_enable && timer0_ovf_flag)
                || (edge_irq_enable && edge_irq_flag)
                || (change_irq_enable && change_summary_flag);
  wire periph_pend = |(periph_flag_reg_a & periph_enable_a)
                  || |(periph_flag_reg_b & periph_enable_b);
  wire any_pend = core_pend || (peripheral_group_enable && periph_pend); // R2
  wire irq_req  = global_irq_enable && any_pend; // R23

  // taken only at Q1 in run state, never counting instruction length
  wire take_now = q1_tick && irq_req && state == irq_ctrl_pkg::ST_RUN; // R12

  // flag next values: hardware set wins over software clear
  wire [7:0] ctl_wr = wr_ctl ? wd : {1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                      timer0_ovf_flag, edge_irq_flag, 1'b0};
  wire next_t0f = ctl_wr[irq_ctrl_pkg::CTL_T0IF] || timer0_ovf_evt; // R3
  wire next_eif = ctl_wr[irq_ctrl_pkg::CTL_EIF] || pin_edge; // R17
  wire [NPERIPH-1:0] next_pfa = (wr_pfa ? wd[NPERIPH-1:0] : periph_flag_reg_a)
                              | periph_evt_a; // R3
  wire [NPERIPH-1:0] next_pfb = (wr_pfb ? wd[NPERIPH-1:0] : periph_flag_reg_b)
                              | periph_evt_b; // R3
  wire [7:0] next_pcf = (wr_pchg ? wd : pin_change_flags) | pin_change_evt;

  // global enable: entry clears, return sets, else software
  wire next_gie = take_now ? 1'b0
                : return_from_irq_op ? 1'b1
                : wr_ctl ? wd[irq_ctrl_pkg::CTL_GIE]
                : global_irq_enable; // R4 R7

  // shadow status drops watchdog_expiry_flag and sleep_entry_flag
  wire [7:0] status_mask = ~((8'h01 << irq_ctrl_pkg::STATUS_TO_BIT)
                           | (8'h01 << irq_ctrl_pkg::STATUS_PD_BIT));
  irq_ctrl_pkg::ctx_t ctx_saved;
  always_comb
  begin
    ctx_saved        = ctx_live;
    ctx_saved.status = ctx_live.status & status_mask; // R18
  end

  // readback mux
  wire [7:0] ctl_rd = {global_irq_enable, peripheral_group_enable,
                       timer0_ovf_enable, edge_irq_enable,
                       change_irq_enable, timer0_ovf_flag,
                       edge_irq_flag, change_summary_flag}; // R21
  wire [7:0] state_rd = {5'h00, irq_req,
                         state == irq_ctrl_pkg::ST_WAKE_STEP,
                         state == irq_ctrl_pkg::ST_SLEEP};
  logic [31:0] rd_mux;
  always_comb
  begin
    case (avs_address)
      irq_ctrl_pkg::OFS_CORE_CTL:  rd_mux = {24'h000000, ctl_rd};
      irq_ctrl_pkg::OFS_PFLAG_A:   rd_mux = 32'(periph_flag_reg_a);
      irq_ctrl_pkg::OFS_PFLAG_B:   rd_mux = 32'(periph_flag_reg_b);
      irq_ctrl_pkg::OFS_PEN_A:     rd_mux = 32'(periph_enable_a);
      irq_ctrl_pkg::OFS_PEN_B:     rd_mux = 32'(periph_enable_b);
      irq_ctrl_pkg::OFS_EDGE_CFG:  rd_mux = {31'h00000000,
                                             edge_polarity_select};
      irq_ctrl_pkg::OFS_PIN_CHG:   rd_mux = {24'h000000, pin_change_flags};
      irq_ctrl_pkg::OFS_STATE:     rd_mux = {24'h000000, state_rd};
      irq_ctrl_pkg::OFS_SH_W:      rd_mux = {24'h000000, shadow.w}; // R20
      irq_ctrl_pkg::OFS_SH_STATUS: rd_mux = {24'h000000, shadow.status};
      irq_ctrl_pkg::OFS_SH_BSR:    rd_mux = {27'h0000000, shadow.bank_select_reg};
      irq_ctrl_pkg::OFS_SH_FSR0:   rd_mux = {16'h0000, shadow.fsr0};
      irq_ctrl_pkg::OFS_SH_FSR1:   rd_mux = {16'h0000, shadow.fsr1};
      irq_ctrl_pkg::OFS_SH_PC_HIGH_LATCH: rd_mux = {25'h0000000, shadow.pc_high_latch};
      default:                     rd_mux = 32'h00000000;
    endcase
  end

  // shadow next value: entry capture beats a software write
  irq_ctrl_pkg::ctx_t next_shadow;
  always_comb
  begin
    next_shadow = shadow;
    if (take_now)
      next_shadow = ctx_saved; // R18
    else
    begin
      if (wr_shw) next_shadow.w = wd; // R20
      if (wr_shs) next_shadow.status = wd & status_mask;
      if (wr_shb) next_shadow.bank_select_reg = wd[4:0];
      if (wr_shp) next_shadow.pc_high_latch = wd[6:0];
      if (sel_f0 && be0) next_shadow.fsr0[7:0] = wd16[7:0];
      if (sel_f0 && be1) next_shadow.fsr0[15:8] = wd16[15:8];
      if (sel_f1 && be0) next_shadow.fsr1[7:0] = wd16[7:0];
      if (sel_f1 && be1) next_shadow.fsr1[15:8] = wd16[15:8];
    end
  end

  // sleep and wake sequencing
  irq_ctrl_pkg::run_state_t next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      irq_ctrl_pkg::ST_RUN:
        if (sleep_enter)
          next_state = irq_ctrl_pkg::ST_SLEEP;
      irq_ctrl_pkg::ST_SLEEP:
        if (any_pend)
          next_state = irq_ctrl_pkg::ST_WAKE_STEP; // R14
      irq_ctrl_pkg::ST_WAKE_STEP:
        if (q1_tick)
          next_state = irq_ctrl_pkg::ST_RUN; // R15
      default:
        next_state = irq_ctrl_pkg::ST_RUN;
    endcase
  end
  wire next_wake = state == irq_ctrl_pkg::ST_SLEEP && any_pend;

  // two flops before the edge detector looks at the pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end
    else
    begin
      pin_s1 <= ext_irq_pin; // R10
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // one wait state per access, answer registered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (rd_go)
        avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      global_irq_enable       <= 1'b0; // R1
      peripheral_group_enable <= 1'b0;
      timer0_ovf_enable       <= 1'b0;
      edge_irq_enable         <= 1'b0;
      change_irq_enable       <= 1'b0;
      timer0_ovf_flag         <= 1'b0;
      edge_irq_flag           <= 1'b0;
      edge_polarity_select    <= 1'b1;
      periph_flag_reg_a       <= '0;
      periph_flag_reg_b       <= '0;
      periph_enable_a         <= '0;
      periph_enable_b         <= '0;
      pin_change_flags        <= irq_ctrl_pkg::RST_BYTE;
    end
    else
    begin
      global_irq_enable <= next_gie; // R6 R8
      if (wr_ctl)
      begin
        peripheral_group_enable <= wd[irq_ctrl_pkg::CTL_PERIPHERAL_GROUP_ENABLE];
        timer0_ovf_enable       <= wd[irq_ctrl_pkg::CTL_T0IE];
        edge_irq_enable         <= wd[irq_ctrl_pkg::CTL_EIE];
        change_irq_enable       <= wd[irq_ctrl_pkg::CTL_CIE];
      end
      timer0_ovf_flag   <= next_t0f;
      edge_irq_flag     <= next_eif;
      periph_flag_reg_a <= next_pfa;
      periph_flag_reg_b <= next_pfb;
      pin_change_flags  <= next_pcf;
      if (wr_pea)
        periph_enable_a <= wd[NPERIPH-1:0];
      if (wr_peb)
        periph_enable_b <= wd[NPERIPH-1:0];
      if (wr_ecfg)
        edge_polarity_select <= wd[0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state             <= irq_ctrl_pkg::ST_RUN;
      shadow            <= '0;
      irq_take          <= 1'b0;
      vector_addr       <= irq_ctrl_pkg::VECTOR_ADDR;
      wake              <= 1'b0;
      ctx_restore_valid <= 1'b0;
      ctx_restore       <= '0;
    end
    else
    begin
      state             <= next_state;
      shadow            <= next_shadow;
      irq_take          <= take_now; // R4 R9 R11
      vector_addr       <= irq_ctrl_pkg::VECTOR_ADDR;
      wake              <= next_wake;
      ctx_restore_valid <= return_from_irq_op; // R7
      if (return_from_irq_op)
        ctx_restore <= shadow; // R19
    end
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence req_at_q1;
    q1_tick && irq_req && state == irq_ctrl_pkg::ST_RUN;
  endsequence
  sequence woken;
    wake;
  endsequence

  reset_quiet_a: assert property (disable iff (1'b0) // R1
    $fell(rst) |-> !global_irq_enable && !irq_take)
    else $error("enable or take active after reset");
  gate_enable_a: assert property ( // R2
    irq_take |-> $past(global_irq_enable) && $past(any_pend))
    else $error("take without enables");
  flag_set_a: assert property ( // R3
    timer0_ovf_evt |=> timer0_ovf_flag)
    else $error("timer0 flag not set");
  entry_save_a: assert property ( // R4
    irq_take |-> !global_irq_enable && shadow.w == $past(ctx_live.w)
      && vector_addr == irq_ctrl_pkg::VECTOR_ADDR)
    else $error("entry did not save or clear enable");
  masked_take_a: assert property ( // R6
    !global_irq_enable |=> !irq_take)
    else $error("take while global enable clear");
  return_restore_a: assert property ( // R7
    return_from_irq_op |=> global_irq_enable && ctx_restore_valid
      && ctx_restore == $past(shadow))
    else $error("return did not restore");
  take_latency_a: assert property ( // R9
    req_at_q1 |=> irq_take ##1 !irq_take)
    else $error("take not one cycle after Q1");
  q1_sample_a: assert property ( // R12
    irq_take |-> $past(q1_tick))
    else $error("take outside Q1");
  wake_step_a: assert property ( // R15
    woken |-> !irq_take [*2])
    else $error("vector before post-sleep step");
  edge_flag_a: assert property ( // R17
    pin_edge |=> edge_irq_flag)
    else $error("edge flag not set");
  status_mask_a: assert property ( // R18
    irq_take |-> shadow.status[irq_ctrl_pkg::STATUS_TO_BIT] == 1'b0
      && shadow.status[irq_ctrl_pkg::STATUS_PD_BIT] == 1'b0)
    else $error("status timeout/sleep bits shadowed");
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule : core_interrupt_controller

// [tb/core_model.sv]
`timescale 1ns/1ps
module core_model (
  input  wire logic               clk,                // core clock
  input  wire logic               rst,                // async, high
  input  wire logic               cmd_sleep,          // bench: run sleep
  input  wire logic               cmd_ret,            // bench: run return
  input  wire logic               wake,               // leave sleep
  input  wire irq_ctrl_pkg::ctx_t ctx_seed,           // next live context
  output logic                    q1_tick,            // Q1 of each cycle
  output logic                    sleep_enter,        // sleep pulse
  output logic                    return_from_irq_op, // return pulse
  output irq_ctrl_pkg::ctx_t      ctx_live            // live context
);
  logic [1:0] phase;
  logic       asleep;

  // no Q1 while halted, since a sleeping core has no instruction cycles
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      phase              <= 2'h0;
      asleep             <= 1'b0;
      q1_tick            <= 1'b0;
      sleep_enter        <= 1'b0;
      return_from_irq_op <= 1'b0;
      ctx_live           <= '0;
    end
    else
    begin
      phase              <= phase + 2'h1;
      asleep             <= (asleep || cmd_sleep) && !wake;
      q1_tick            <= (phase == 2'h3) && !asleep && !cmd_sleep;
      sleep_enter        <= cmd_sleep;
      return_from_irq_op <= cmd_ret;
      ctx_live           <= ctx_seed;
    end
endmodule : core_model

// [tb/core_interrupt_controller_tb_top.sv]
`timescale 1ns/1ps
module core_interrupt_controller_tb_top;
  logic               clk;
  logic               rst;
  logic [7:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               q1_tick;
  logic               timer0_ovf_evt;
  logic [7:0]         periph_evt_a;
  logic [7:0]         periph_evt_b;
  logic [7:0]         pin_change_evt;
  logic               ext_irq_pin;
  logic               sleep_enter;
  logic               return_from_irq_op;
  logic               cmd_sleep;
  logic               cmd_ret;
  logic               irq_take;
  logic [15:0]        vector_addr;
  logic               wake;
  logic               ctx_restore_valid;
  logic               post_wake;
  logic [7:0]         bit_a;
  irq_ctrl_pkg::ctx_t ctx_live;
  irq_ctrl_pkg::ctx_t ctx_restore;
  irq_ctrl_pkg::ctx_t ctx_seed;
  irq_ctrl_pkg::ctx_t exp;
  irq_ctrl_pkg::ctx_t nx;
  logic [31:0]        rd_q[$];
  irq_ctrl_pkg::ctx_t ctx_q[$];
  int                 take_q[$];
  int                 wake_q[$];
  int                 bad_count;
  int                 n_checks;
  int                 q1_since_wake;

  core_interrupt_controller dut (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .q1_tick(q1_tick), .timer0_ovf_evt(timer0_ovf_evt),
    .periph_evt_a(periph_evt_a), .periph_evt_b(periph_evt_b),
    .pin_change_evt(pin_change_evt), .ext_irq_pin(ext_irq_pin),
    .sleep_enter(sleep_enter), .return_from_irq_op(return_from_irq_op),
    .ctx_live(ctx_live), .irq_take(irq_take), .vector_addr(vector_addr),
    .wake(wake), .ctx_restore_valid(ctx_restore_valid),
    .ctx_restore(ctx_restore));

  core_model core (.clk(clk), .rst(rst), .cmd_sleep(cmd_sleep),
    .cmd_ret(cmd_ret), .wake(wake), .ctx_seed(ctx_seed), .q1_tick(q1_tick),
    .sleep_enter(sleep_enter), .return_from_irq_op(return_from_irq_op),
    .ctx_live(ctx_live));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic chk32(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask : chk32

  task automatic chkctx(input irq_ctrl_pkg::ctx_t e,
                        input irq_ctrl_pkg::ctx_t g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected ctx_restore exp %h got %h", e, g);
    end
  endtask : chkctx

  function automatic irq_ctrl_pkg::ctx_t masked(input irq_ctrl_pkg::ctx_t c);
    c.status[irq_ctrl_pkg::STATUS_TO_BIT] = 1'b0;
    c.status[irq_ctrl_pkg::STATUS_PD_BIT] = 1'b0;
    return c;
  endfunction : masked

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one access; the trailing idle edge keeps back-to-back calls legal
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    chk32("bus answer", 32'(n < 50), 32'h1);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic evt(input logic t0, input logic [7:0] pa,
                     input logic [7:0] pc);
    timer0_ovf_evt <= t0;
    periph_evt_a   <= pa;
    periph_evt_b   <= pa;
    pin_change_evt <= pc;
    @(posedge clk);
    timer0_ovf_evt <= 1'b0;
    periph_evt_a   <= 8'h00;
    periph_evt_b   <= 8'h00;
    pin_change_evt <= 8'h00;
  endtask : evt

  // waits until every noted take, wake and restore has shown up
  task automatic await_note(input int lim);
    int n;
    n = 0;
    while (take_q.size() + wake_q.size() + ctx_q.size() != 0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk32("latency", 32'(n < lim), 32'h1);
  endtask : await_note

  task automatic ret(input irq_ctrl_pkg::ctx_t e);
    ctx_q.push_back(e);
    cmd_ret <= 1'b1;
    @(posedge clk);
    cmd_ret <= 1'b0;
    await_note(16);
  endtask : ret

  task automatic do_sleep();
    cmd_sleep <= 1'b1;
    @(posedge clk);
    cmd_sleep <= 1'b0;
    tick(4);
  endtask : do_sleep

  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk32("readdata", rd_q.pop_front(), avs_readdata);
    if (q1_tick === 1'b1)
      q1_since_wake++;
    if (wake === 1'b1)
    begin
      chk32("wake noted", 32'(wake_q.size() > 0), 32'h1);
      q1_since_wake = 0;
      if (wake_q.size() > 0)
        wake_q.delete(0);
    end
    if (irq_take === 1'b1)
    begin
      chk32("take noted", 32'(take_q.size() > 0), 32'h1);
      chk32("vector", 32'h4, {16'h0, vector_addr});
      if (post_wake)
        chk32("q1 after wake", 32'(q1_since_wake >= 2), 32'h1);
      if (take_q.size() > 0)
        take_q.delete(0);
    end
    if (ctx_restore_valid === 1'b1)
    begin
      chk32("restore noted", 32'(ctx_q.size() > 0), 32'h1);
      if (ctx_q.size() > 0)
        chkctx(ctx_q.pop_front(), ctx_restore);
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial
  begin
    rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {timer0_ovf_evt, periph_evt_a, pin_change_evt, ext_irq_pin} = '0;
    periph_evt_b = '0;
    avs_byteenable = 4'hF;
    {cmd_sleep, cmd_ret, post_wake} = '0;
    ctx_seed = '0;
    void'($urandom(32'hC083B978));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h0);
    rd(irq_ctrl_pkg::OFS_EDGE_CFG, 32'h1);
    rd(8'h3C, 32'h0);
    bit_a = 8'h01 << ($urandom() % 8);
    evt(1'b1, bit_a, 8'($urandom()) | 8'h01);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h05);
    rd(irq_ctrl_pkg::OFS_PFLAG_A, {24'h0, bit_a});
    rd(irq_ctrl_pkg::OFS_PFLAG_B, {24'h0, bit_a});
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h0);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h01);
    wr(irq_ctrl_pkg::OFS_PIN_CHG, 32'h0);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h0);
    ctx_seed <= irq_ctrl_pkg::ctx_t'(60'({$urandom(), $urandom()}));
    wr(irq_ctrl_pkg::OFS_PEN_A, {24'h0, bit_a});
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h80);
    tick(20);
    take_q.push_back(1);
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'hC0);
    await_note(16);
    wr(irq_ctrl_pkg::OFS_PFLAG_A, 32'h0);
    ret(masked(ctx_seed));
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'hC0);
    ctx_seed <= irq_ctrl_pkg::ctx_t'(60'({$urandom(), $urandom()}));
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'hA0);
    exp = masked(ctx_seed);
    take_q.push_back(1);
    evt(1'b1, 8'h00, 8'h00);
    await_note(16);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h24);
    rd(irq_ctrl_pkg::OFS_SH_W, {24'h0, exp.w});
    rd(irq_ctrl_pkg::OFS_SH_STATUS, {24'h0, exp.status});
    rd(irq_ctrl_pkg::OFS_SH_FSR1, {16'h0, exp.fsr1});
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h20);
    evt(1'b1, 8'h00, 8'h00);
    tick(20);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h24);
    wr(irq_ctrl_pkg::OFS_SH_W, 32'h5A);
    exp.w = 8'h5A;
    // upper lane only: the low byte of the pointer must survive
    avs_byteenable <= 4'h2;
    wr(irq_ctrl_pkg::OFS_SH_FSR1, 32'h0000FFFF);
    avs_byteenable <= 4'hF;
    exp.fsr1[15:8] = 8'hFF;
    rd(irq_ctrl_pkg::OFS_SH_FSR1, {16'h0, exp.fsr1});
    ctx_seed <= irq_ctrl_pkg::ctx_t'(60'({$urandom(), $urandom()}));
    tick(2);
    nx = masked(ctx_seed);
    take_q.push_back(1);
    ret(exp);
    rd(irq_ctrl_pkg::OFS_SH_W, {24'h0, nx.w});
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h20);
    ret(nx);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'hA0);
    for (int p = 1; p >= 0; p--)
    begin
      // global off first, else the priming edge would vector
      wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h10);
      wr(irq_ctrl_pkg::OFS_EDGE_CFG, 32'(p));
      ext_irq_pin <= p[0];
      tick(10);
      wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h10);
      ext_irq_pin <= !p[0];
      tick(10);
      rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h10);
      wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h90);
      take_q.push_back(1);
      ext_irq_pin <= p[0];
      await_note(20);
      rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h12);
      wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h10);
      ret(masked(ctx_seed));
    end
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h20);
    do_sleep();
    wake_q.push_back(1);
    evt(1'b1, 8'h00, 8'h00);
    await_note(16);
    tick(20);
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'hA0);
    do_sleep();
    post_wake = 1'b1;
    wake_q.push_back(1);
    take_q.push_back(1);
    evt(1'b1, 8'h00, 8'h00);
    await_note(24);
    post_wake = 1'b0;
    wr(irq_ctrl_pkg::OFS_CORE_CTL, 32'h20);
    ret(masked(ctx_seed));
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    @(posedge clk);
    rd(irq_ctrl_pkg::OFS_CORE_CTL, 32'h0);
    rd(irq_ctrl_pkg::OFS_SH_W, 32'h0);
    conclude();
  end
endmodule : core_interrupt_controller_tb_top
